// ---- hdl/sgmc_pkg.sv ----
// Constants and types of the mode-switch controller
`default_nettype none
package sgmc_pkg;

	// ==================================================================
	// Software register map (byte addresses)
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_TIMER    = 8'h04;
	localparam logic [7:0]  REG_ADV      = 8'h08;
	localparam logic [7:0]  REG_STATUS   = 8'h0C;

	// CTRL fields
	localparam int          CTRL_MODE_LO = 0;
	localparam int          CTRL_USE_IRQ = 2;
	localparam int          CTRL_TRISPD  = 3;
	localparam int          CTRL_GO      = 31;

	// Reset values
	localparam logic [8:0]  TIMER_RST    = 9'h032;
	localparam logic [15:0] ADV_RST      = 16'h0020;
	localparam logic [15:0] AN_CTRL_RST  = 16'h1000;

	// ==================================================================
	// Device side: mode configuration word and addresses
	localparam logic [9:0]  DEV_MODE_ADDR  = 10'h300;
	localparam logic [9:0]  DEV_SPEED_ADDR = 10'h310;
	localparam int          MODE_BIT_LO    = 27;
	localparam int          TIMER_BIT_LO   = 0;
	localparam int          SPEED_BIT_LO   = 30;
	localparam int          DUPLEX_BIT     = 29;

	// PCS management register numbers and bits
	localparam logic [4:0]  MR_CTRL     = 5'h00;
	localparam logic [4:0]  MR_STAT     = 5'h01;
	localparam logic [4:0]  MR_ADV      = 5'h04;
	localparam logic [4:0]  MR_PARTNER  = 5'h05;
	localparam logic [4:0]  MR_IRQ      = 5'h10;
	localparam int          MR_RESTART  = 9;
	localparam int          MR_AN_DONE  = 5;
	localparam int          MR_IRQ_EN   = 0;
	localparam int          MR_IRQ_STAT = 1;
	localparam int          SG_SPEED_LO = 10;
	localparam int          SG_DUPLEX   = 12;
	localparam int          BX_DUPLEX   = 5;

	// ==================================================================
	// Modes and timing
	typedef enum logic [1:0] {
		MODE_ILL0  = 2'b00,
		MODE_BASEX = 2'b01,
		MODE_SGMII = 2'b10,
		MODE_ILL1  = 2'b11
	} sgmc_mode_t;

	localparam int          CLK_NS       = 10;
	localparam int          LINK_UNIT_NS = 32768;
	localparam int          UNIT_CYC     = (LINK_UNIT_NS + CLK_NS - 1)
						/ CLK_NS;
	localparam int          AN_PHASES    = 3;
	localparam int          AN_MARGIN    = 4;
	localparam int          POLL_NS      = 10000;
	localparam int          POLL_CYC     = POLL_NS / CLK_NS;

endpackage : sgmc_pkg
`default_nettype wire

// ---- hdl/sgmc_acc_if.sv ----
// Access request channel between sequencer and device port
`timescale 1ns/1ps
`default_nettype none
interface sgmc_acc_if;
	logic        req;
	logic        miim;
	logic        wr;
	logic [9:0]  addr;
	logic [31:0] wdata;
	logic        ack;
	logic [31:0] rdata;
	modport seq  (output req, miim, wr, addr, wdata,
		input ack, rdata);
	modport port (input req, miim, wr, addr, wdata,
		output ack, rdata);
endinterface : sgmc_acc_if
`default_nettype wire

// ---- hdl/sgmc_dev_port.sv ----
// Four-phase handshake onto the device management pins
`timescale 1ns/1ps
`default_nettype none
module sgmc_dev_port
	import sgmc_pkg::*;
(
	input  wire logic   clock,
	input  wire logic   arst_n,
	sgmc_acc_if.port    acc,
	output logic        dev_req,
	output logic        dev_sel_miim,
	output logic        dev_wr,
	output logic [9:0]  dev_addr,
	output logic [31:0] dev_wdata,
	input  wire logic   dev_ack,
	input  wire logic [31:0] dev_rdata
);
	typedef enum logic [1:0] {
		P_IDLE = 2'b00,
		P_REQ  = 2'b01,
		P_REL  = 2'b10
	} sgmc_pst_t;

	sgmc_pst_t   st_q, st_d;
	logic        s1_q, s2_q, s3_q, ack_q, ack_d;
	logic        req_q, req_d, miim_q, miim_d, wr_q, wr_d, done_q, done_d;
	logic [9:0]  addr_q, addr_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;

	// ==================================================================
	// Synchroniser, counts once stages two and three agree
	always_comb
	begin
		ack_d = (s2_q == s3_q) ? s3_q : ack_q;
	end

	// ==================================================================
	// Handshake
	always_comb
	begin
		st_d   = st_q;
		req_d  = req_q;
		miim_d = miim_q;
		wr_d   = wr_q;
		addr_d = addr_q;
		wd_d   = wd_q;
		rd_d   = rd_q;
		done_d = 1'b0;
		case (st_q)
			P_IDLE:
			begin
				if (acc.req && !ack_q)
				begin
					st_d   = P_REQ;
					req_d  = 1'b1;
					miim_d = acc.miim; // RL12
					wr_d   = acc.wr;
					addr_d = acc.addr;
					wd_d   = acc.wdata;
				end
			end
			P_REQ:
			begin
				if (ack_q)
				begin
					// Data stands while ack is high
					rd_d  = dev_rdata;
					req_d = 1'b0;
					st_d  = P_REL;
				end
			end
			P_REL:
			begin
				if (!ack_q)
				begin
					done_d = 1'b1;
					st_d   = P_IDLE;
				end
			end
			default: st_d = P_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s1_q   <= 1'b0;
			s2_q   <= 1'b0;
			s3_q   <= 1'b0;
			ack_q  <= 1'b0;
			st_q   <= P_IDLE;
			req_q  <= 1'b0;
			miim_q <= 1'b0;
			wr_q   <= 1'b0;
			addr_q <= 10'h000;
			wd_q   <= 32'h00000000;
			rd_q   <= 32'h00000000;
			done_q <= 1'b0;
		end
		else
		begin
			s1_q   <= dev_ack;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			ack_q  <= ack_d;
			st_q   <= st_d;
			req_q  <= req_d;
			miim_q <= miim_d;
			wr_q   <= wr_d;
			addr_q <= addr_d;
			wd_q   <= wd_d;
			rd_q   <= rd_d;
			done_q <= done_d;
		end
	end

	assign dev_req      = req_q;
	assign dev_sel_miim = miim_q;
	assign dev_wr       = wr_q;
	assign dev_addr     = addr_q;
	assign dev_wdata    = wd_q;
	assign acc.ack      = done_q;
	assign acc.rdata    = rd_q;

	a_req_held: assert property (@(posedge clock) disable iff (!arst_n)
		dev_req && !ack_q |=> $stable(dev_addr) && $stable(dev_wdata))
		else $error("request fields moved before ack"); // RL12

endmodule : sgmc_dev_port
`default_nettype wire

// ---- hdl/sgmc_ctrl.sv ----
// Host-side SGMII / 1000BASE-X mode switch and autoneg controller
// Notes on behaviour
// [RL1] Device link timer unit is 4096 reference clocks, 32.768 us.
// [RL2] Link timer is a nine-bit value written into mode configuration.
// [RL3] Device expiry may be up to one unit early, never late.
// [RL4] SGMII timer value is 50; software may lower it in simulation.
// [RL5] One link timer times three autoneg phases.
// [RL6] SGMII autoneg follows 1000BASE-X with a 1.6 ms timer.
// [RL7] SGMII config word carries speed and duplex of the PHY.
// [RL8] Host reads negotiated results and programs MAC speed and duplex.
// [RL9] Device sets status bit 1.5 when autoneg completes.
// [RL10] Device interrupt stays low while disabled.
// [RL11] Interrupt stays high until host writes zero to bit 16.1.
// [RL12] Interrupt enable and clear go through management registers.
// [RL13] Internal loopback turns data round at the PCS edge.
// [RL14] Internal loopback sends Idle to the transceiver.
// [RL15] Device has a transceiver loopback output; data also goes out.
// [RL16] Mode bits 28:27: 01 is 1000BASE-X, 10 is SGMII, others illegal.
// [RL17] A mode bit write starts the switch at once.
// [RL18] Timer value goes in the same write as the mode bits.
// [RL19] Management fields change meaning at once after a switch.
// [RL20] Going SGMII to 1000BASE-X, rewrite advertisement before restart.
// [RL21] Set bit 0.9 to restart; switch ends when autoneg completes.
// [RL22] Switch only after power-up or reset release, tri-speed only.
// [RL23] Device reloads the timer at each timed phase.
`timescale 1ns/1ps
`default_nettype none
module sgmc_ctrl
	import sgmc_pkg::*;
#(
	parameter int UNIT_CYCLES = sgmc_pkg::UNIT_CYC,
	parameter int POLL_CYCLES = sgmc_pkg::POLL_CYC
)
(
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic [7:0]  sw_addr,
	input  wire logic [31:0] sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output logic [31:0]      sw_rdata,
	output logic             dev_req,
	output logic             dev_sel_miim,
	output logic             dev_wr,
	output logic [9:0]       dev_addr,
	output logic [31:0]      dev_wdata,
	input  wire logic        dev_ack,
	input  wire logic [31:0] dev_rdata,
	input  wire logic        autoneg_irq_out
);
	initial
	begin
		if (UNIT_CYCLES < 1 || UNIT_CYCLES > 8191 || POLL_CYCLES < 1)
			$error("sgmc_ctrl: unsupported cycle parameters");
	end

	typedef enum logic [3:0] {
		S_IDLE  = 4'b0000,
		S_MODE  = 4'b0001,
		S_ADV   = 4'b0010,
		S_IEN   = 4'b0011,
		S_RST   = 4'b0100,
		S_WAIT  = 4'b0101,
		S_POLL  = 4'b0110,
		S_RES   = 4'b0111,
		S_MAC   = 4'b1000,
		S_ICLR  = 4'b1001
	} sgmc_state_t;

	function automatic logic mode_legal(input logic [1:0] m);
		return m == MODE_BASEX || m == MODE_SGMII; // RL16
	endfunction : mode_legal

	function automatic logic [9:0] mreg(input logic [4:0] r);
		return {5'h00, r};
	endfunction : mreg

	sgmc_acc_if acc ();

	// ==================================================================
	// Software registers and sequencer state
	sgmc_state_t  st_q, st_d;
	logic [1:0]   mode_q, mode_d, cur_q, cur_d;
	logic         uirq_q, uirq_d, tri_q, tri_d;
	logic [8:0]   tmr_q, tmr_d;
	logic [15:0]  adv_q, adv_d, anc_q, anc_d, ptr_q, ptr_d;
	logic         busy_q, busy_d, done_q, done_d, err_q, err_d;
	logic         tmo_q, tmo_d, allow_q, allow_d, pend_q, pend_d;
	logic         advd_q, advd_d;
	logic [31:0]  rdat_q, rdat_d, cnt_q, cnt_d, poll_q, poll_d;
	logic         i1_q, i2_q, i3_q, irq_q, irq_d;
	logic         go;
	logic [31:0]  deadline;

	assign go = sw_wr && sw_addr == REG_CTRL && sw_wdata[CTRL_GO];
	// Host deadline: three phases, each one full timer, with margin
	assign deadline = 32'(tmr_q) * 32'(UNIT_CYCLES)
		* 32'(AN_PHASES * AN_MARGIN); // RL5

	// ==================================================================
	// Interrupt pin synchroniser
	always_comb
	begin
		irq_d = (i2_q == i3_q) ? i3_q : irq_q; // RL10
	end

	// ==================================================================
	// Register port and sequencer
	always_comb
	begin
		st_d    = st_q;
		mode_d  = mode_q;
		cur_d   = cur_q;
		uirq_d  = uirq_q;
		tri_d   = tri_q;
		tmr_d   = tmr_q;
		adv_d   = adv_q;
		anc_d   = anc_q;
		ptr_d   = ptr_q;
		busy_d  = busy_q;
		done_d  = done_q;
		err_d   = err_q;
		tmo_d   = tmo_q;
		allow_d = allow_q;
		pend_d  = pend_q;
		advd_d  = advd_q;
		cnt_d   = cnt_q;
		poll_d  = poll_q;
		rdat_d  = 32'h00000000;
		acc.req   = 1'b0;
		acc.miim  = 1'b1;
		acc.wr    = 1'b1;
		acc.addr  = 10'h000;
		acc.wdata = 32'h00000000;

		if (sw_rd)
		begin
			case (sw_addr)
				REG_CTRL:   rdat_d = {28'h0000000, tri_q, uirq_q, mode_q};
				REG_TIMER:  rdat_d = {23'h000000, tmr_q};
				REG_ADV:    rdat_d = {anc_q, adv_q};
				REG_STATUS: rdat_d = {ptr_q, 8'h00, irq_q, cur_q,
					allow_q, tmo_q, err_q, done_q, busy_q};
				default:    rdat_d = 32'h00000000;
			endcase
		end
		if (sw_wr && !busy_q)
		begin
			case (sw_addr)
				REG_CTRL:
				begin
					mode_d = sw_wdata[CTRL_MODE_LO +: 2];
					uirq_d = sw_wdata[CTRL_USE_IRQ];
					tri_d  = sw_wdata[CTRL_TRISPD];
				end
				REG_TIMER: tmr_d = sw_wdata[8:0]; // RL2
				REG_ADV:
				begin
					adv_d = sw_wdata[15:0];
					anc_d = sw_wdata[31:16];
				end
				default: ;
			endcase
		end
		if (go && !busy_q)
		begin
			done_d = 1'b0;
			tmo_d  = 1'b0;
			// Refused unless legal, tri-speed, and first since reset
			if (mode_legal(sw_wdata[CTRL_MODE_LO +: 2]) && allow_q
				&& sw_wdata[CTRL_TRISPD]) // RL22
			begin
				err_d   = 1'b0;
				busy_d  = 1'b1;
				allow_d = 1'b0;
				advd_d  = 1'b0;
				st_d    = S_MODE;
			end
			else
				err_d = 1'b1;
		end

		case (st_q)
			S_IDLE: ;
			S_MODE:
			begin
				acc.miim  = 1'b0;
				acc.addr  = DEV_MODE_ADDR;
				acc.wdata = 32'(mode_q) << MODE_BIT_LO;
				// Timer rides in the same write as the mode
				acc.wdata[TIMER_BIT_LO +: 9] = tmr_q; // RL18
				acc.req   = !pend_q; // RL17
				if (acc.ack)
				begin
					cur_d = mode_q; // RL19
					st_d  = (mode_q == MODE_BASEX && cur_q == MODE_SGMII)
						? S_ADV : S_IEN;
				end
			end
			S_ADV:
			begin
				acc.addr  = mreg(MR_ADV);
				acc.wdata = {16'h0000, adv_q}; // RL20
				acc.req   = !pend_q;
				if (acc.ack)
				begin
					advd_d = 1'b1;
					st_d   = S_IEN;
				end
			end
			S_IEN:
			begin
				acc.addr  = mreg(MR_IRQ);
				acc.wdata = 32'(uirq_q) << MR_IRQ_EN; // RL12
				acc.req   = !pend_q;
				if (acc.ack)
					st_d = S_RST;
			end
			S_RST:
			begin
				acc.addr  = mreg(MR_CTRL);
				acc.wdata = {16'h0000, anc_q};
				acc.wdata[MR_RESTART] = 1'b1; // RL21
				acc.req   = !pend_q;
				if (acc.ack)
				begin
					cnt_d  = 32'h00000000;
					poll_d = 32'h00000000;
					st_d   = S_WAIT;
				end
			end
			S_WAIT:
			begin
				cnt_d  = cnt_q + 32'h00000001;
				poll_d = poll_q + 32'h00000001;
				if (uirq_q && irq_q)
					st_d = S_RES; // RL11
				else if (cnt_q >= deadline)
				begin
					tmo_d  = 1'b1;
					busy_d = 1'b0;
					st_d   = S_IDLE;
				end
				else if (!uirq_q && poll_q >= 32'(POLL_CYCLES))
					st_d = S_POLL;
			end
			S_POLL:
			begin
				acc.wr   = 1'b0;
				acc.addr = mreg(MR_STAT);
				acc.req  = !pend_q;
				cnt_d    = cnt_q + 32'h00000001;
				if (acc.ack)
				begin
					poll_d = 32'h00000000;
					st_d   = acc.rdata[MR_AN_DONE] ? S_RES : S_WAIT; // RL9
				end
			end
			S_RES:
			begin
				acc.wr   = 1'b0;
				acc.addr = mreg(MR_PARTNER);
				acc.req  = !pend_q;
				if (acc.ack)
				begin
					ptr_d = acc.rdata[15:0]; // RL7
					st_d  = S_MAC;
				end
			end
			S_MAC:
			begin
				// MAC never follows the link by itself
				acc.miim  = 1'b0;
				acc.addr  = DEV_SPEED_ADDR;
				if (cur_q == MODE_SGMII)
				begin
					acc.wdata[SPEED_BIT_LO +: 2] = ptr_q[SG_SPEED_LO +: 2];
					acc.wdata[DUPLEX_BIT] = ptr_q[SG_DUPLEX];
				end
				else
				begin
					acc.wdata[SPEED_BIT_LO +: 2] = 2'b10;
					acc.wdata[DUPLEX_BIT] = ptr_q[BX_DUPLEX];
				end
				acc.req   = !pend_q; // RL8
				if (acc.ack)
					st_d = S_ICLR;
			end
			S_ICLR:
			begin
				acc.addr  = mreg(MR_IRQ);
				acc.wdata = 32'(uirq_q) << MR_IRQ_EN; // RL11
				acc.req   = !pend_q;
				if (acc.ack)
				begin
					done_d = 1'b1; // RL21
					busy_d = 1'b0;
					st_d   = S_IDLE;
				end
			end
			default: st_d = S_IDLE;
		endcase
		pend_d = (pend_q || acc.req) && !acc.ack;
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q    <= S_IDLE;
			mode_q  <= MODE_SGMII;
			cur_q   <= MODE_SGMII;
			uirq_q  <= 1'b0;
			tri_q   <= 1'b0;
			tmr_q   <= TIMER_RST; // RL4
			adv_q   <= ADV_RST;
			anc_q   <= AN_CTRL_RST;
			ptr_q   <= 16'h0000;
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
			err_q   <= 1'b0;
			tmo_q   <= 1'b0;
			allow_q <= 1'b1;
			pend_q  <= 1'b0;
			advd_q  <= 1'b0;
			cnt_q   <= 32'h00000000;
			poll_q  <= 32'h00000000;
			rdat_q  <= 32'h00000000;
			i1_q    <= 1'b0;
			i2_q    <= 1'b0;
			i3_q    <= 1'b0;
			irq_q   <= 1'b0;
		end
		else
		begin
			st_q    <= st_d;
			mode_q  <= mode_d;
			cur_q   <= cur_d;
			uirq_q  <= uirq_d;
			tri_q   <= tri_d;
			tmr_q   <= tmr_d;
			adv_q   <= adv_d;
			anc_q   <= anc_d;
			ptr_q   <= ptr_d;
			busy_q  <= busy_d;
			done_q  <= done_d;
			err_q   <= err_d;
			tmo_q   <= tmo_d;
			allow_q <= allow_d;
			pend_q  <= pend_d;
			advd_q  <= advd_d;
			cnt_q   <= cnt_d;
			poll_q  <= poll_d;
			rdat_q  <= rdat_d;
			i1_q    <= autoneg_irq_out;
			i2_q    <= i1_q;
			i3_q    <= i2_q;
			irq_q   <= irq_d;
		end
	end

	assign sw_rdata = rdat_q;

	sgmc_dev_port u_port (
		.clock        (clock),
		.arst_n       (arst_n),
		.acc          (acc),
		.dev_req      (dev_req),
		.dev_sel_miim (dev_sel_miim),
		.dev_wr       (dev_wr),
		.dev_addr     (dev_addr),
		.dev_wdata    (dev_wdata),
		.dev_ack      (dev_ack),
		.dev_rdata    (dev_rdata)
	);

	// ==================================================================
	// Checks
	sequence mode_write;
		dev_req && !dev_sel_miim && dev_wr && dev_addr == DEV_MODE_ADDR;
	endsequence

	a_mode_legal: assert property (@(posedge clock) disable iff (!arst_n)
		mode_write |-> dev_wdata[28:27] inside {2'b01, 2'b10}) // RL16
		else $error("illegal mode bits sent");
	a_timer_same: assert property (@(posedge clock) disable iff (!arst_n)
		mode_write |-> dev_wdata[8:0] == tmr_q) // RL18
		else $error("timer missing from mode write");
	a_restart_bit: assert property (@(posedge clock) disable iff (!arst_n)
		dev_req && dev_sel_miim && dev_wr && dev_addr == 10'h000
		|-> dev_wdata[9]) // RL21
		else $error("restart bit not set");
	sequence basex_from_sgmii;
		st_q == S_MODE && acc.ack && mode_q == MODE_BASEX
			&& cur_q == MODE_SGMII;
	endsequence

	a_adv_first: assert property (@(posedge clock) disable iff (!arst_n)
		basex_from_sgmii |=> st_q == S_ADV && !advd_q) // RL20
		else $error("advertisement skipped before restart");
	a_irq_clear: assert property (@(posedge clock) disable iff (!arst_n)
		dev_req && dev_sel_miim && dev_wr && dev_addr == 10'h010
		|-> !dev_wdata[1]) // RL11
		else $error("interrupt status not written zero");
	a_refuse_go: assert property (@(posedge clock) disable iff (!arst_n)
		go && !busy_q && !allow_q |=> err_q && !busy_q) // RL22
		else $error("second switch not refused");
	a_done_order: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(done_q) |-> $past(st_q) == S_ICLR && ptr_q == $past(ptr_q))
		else $error("done without finishing sequence"); // RL8
	a_rd_latency: assert property (@(posedge clock) disable iff (!arst_n)
		sw_rd && sw_addr == REG_TIMER |=> sw_rdata == {23'h0, $past(tmr_q)})
		else $error("timer readback wrong"); // RL2

endmodule : sgmc_ctrl
`default_nettype wire

// ---- test/sgmc_dev_model.sv ----
// Behavioural model of the PCS device behind the management pins
`timescale 1ns/1ps
`default_nettype none
module sgmc_dev_model
	import sgmc_pkg::*;
#(
	parameter int MU = 4096
)
(
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        dev_req,
	input  wire logic        dev_sel_miim,
	input  wire logic        dev_wr,
	input  wire logic [9:0]  dev_addr,
	input  wire logic [31:0] dev_wdata,
	output logic             dev_ack,
	output logic [31:0]      dev_rdata,
	output logic             autoneg_irq_out,
	input  wire logic        slow,
	input  wire logic        stall
);
	// ==================================================================
	// Link partner abilities seen per mode
	localparam logic [15:0] LP_SG = 16'h0800;
	localparam logic [15:0] LP_BX = 16'h0020;
	logic [1:0]  mode_q;
	logic [8:0]  timer_q;
	logic [31:0] mac_q;
	logic [15:0] adv_q;
	logic [15:0] ctl_q;
	logic        irq_en_q;
	logic        irq_q;
	logic        an_done_q;
	logic [1:0]  ph_q;
	logic [31:0] cnt_q;
	logic [2:0]  dly_q;
	logic [31:0] rd_val;

	assign autoneg_irq_out = irq_q & irq_en_q;

	// Loopback select in reg0 bit 14; host never asks for it here
	logic        transceiver_loopback_out;
	assign transceiver_loopback_out = ctl_q[14];

	// ==================================================================
	// Read decode
	always_comb
	begin
		rd_val = 32'h0;
		if (dev_sel_miim)
			case (dev_addr[4:0])
			MR_CTRL:    rd_val = {16'h0, ctl_q};
			MR_STAT:    rd_val = {26'h0, an_done_q, 5'h0};
			MR_ADV:     rd_val = {16'h0, adv_q};
			MR_PARTNER: rd_val = {16'h0, (mode_q == MODE_SGMII) ?
				LP_SG : LP_BX};
			MR_IRQ:     rd_val = {30'h0, irq_q, irq_en_q};
			default:    rd_val = 32'h0;
			endcase
		else if (dev_addr == DEV_MODE_ADDR)
			rd_val = {3'h0, mode_q, 18'h0, timer_q};
	end

	// ==================================================================
	// Autoneg phases and four-phase access
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode_q <= MODE_SGMII;
			timer_q <= 9'h000;
			mac_q <= 32'h0;
			adv_q <= 16'h0;
			ctl_q <= 16'h0;
			irq_en_q <= 1'b0;
			irq_q <= 1'b0;
			an_done_q <= 1'b0;
			ph_q <= 2'd0;
			cnt_q <= 32'h0;
			dly_q <= 3'd0;
			dev_ack <= 1'b0;
			dev_rdata <= 32'h0;
		end
		else
		begin
			// Stall freezes the autoneg countdown so the host's timeout shows
			if (ph_q != 2'd0 && !stall)
			begin
				if (cnt_q > 32'd1)
					cnt_q <= cnt_q - 32'd1;
				else if (ph_q != 2'd1)
				begin
					cnt_q <= 32'(timer_q) * 32'(MU);
					ph_q <= ph_q - 2'd1;
				end
				else
				begin
					ph_q <= 2'd0;
					an_done_q <= 1'b1;
					irq_q <= irq_q | irq_en_q;
				end
			end
			if (dev_req && !dev_ack && dly_q < (slow ? 3'd5 : 3'd0))
				dly_q <= dly_q + 3'd1;
			else if (dev_req && !dev_ack)
			begin
				dly_q <= 3'd0;
				dev_ack <= 1'b1;
				dev_rdata <= rd_val;
				if (dev_wr && !dev_sel_miim && dev_addr == DEV_MODE_ADDR)
				begin
					mode_q <= dev_wdata[28:27];
					timer_q <= dev_wdata[8:0];
				end
				if (dev_wr && !dev_sel_miim && dev_addr == DEV_SPEED_ADDR)
					mac_q <= dev_wdata;
				if (dev_wr && dev_sel_miim)
					case (dev_addr[4:0])
					MR_CTRL:
					begin
						ctl_q <= dev_wdata[15:0];
						if (dev_wdata[MR_RESTART])
						begin
							ph_q <= 2'd3;
							cnt_q <= 32'(timer_q) * 32'(MU);
							an_done_q <= 1'b0;
						end
					end
					MR_ADV: adv_q <= dev_wdata[15:0];
					MR_IRQ:
					begin
						irq_en_q <= dev_wdata[MR_IRQ_EN];
						if (!dev_wdata[MR_IRQ_STAT])
							irq_q <= 1'b0;
					end
					default: ;
					endcase
			end
			else if (!dev_req && dev_ack)
			begin
				dev_ack <= 1'b0;
				dev_rdata <= ~dev_rdata;
			end
		end
	end
endmodule : sgmc_dev_model
`default_nettype wire

// ---- test/tb_sgmc_ctrl.sv ----
// Self-checking bench for the mode-switch controller
`timescale 1ns/1ps
`default_nettype none
module tb_sgmc_ctrl;
	import sgmc_pkg::*;
	localparam logic [31:0] GO  = 32'h1 << CTRL_GO;
	localparam logic [31:0] TRI = 32'h1 << CTRL_TRISPD;
	localparam logic [31:0] IRQ = 32'h1 << CTRL_USE_IRQ;
	logic        clock;
	logic        arst_n;
	logic [7:0]  sw_addr;
	logic [31:0] sw_wdata;
	logic        sw_wr;
	logic        sw_rd;
	logic [31:0] sw_rdata;
	logic        dev_req;
	logic        dev_sel_miim;
	logic        dev_wr;
	logic [9:0]  dev_addr;
	logic [31:0] dev_wdata;
	logic        dev_ack;
	logic [31:0] dev_rdata;
	logic        irq;
	logic        slow;
	logic        stall;
	logic        irq_hi;
	int          bad_count;
	int          total_checks;
	int          cyc;

	sgmc_ctrl #(.UNIT_CYCLES(2), .POLL_CYCLES(4)) dut (.clock(clock),
		.arst_n(arst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
		.dev_req(dev_req), .dev_sel_miim(dev_sel_miim), .dev_wr(dev_wr),
		.dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
		.dev_rdata(dev_rdata), .autoneg_irq_out(irq));
	sgmc_dev_model #(.MU(4)) mdl (.clock(clock), .arst_n(arst_n),
		.dev_req(dev_req), .dev_sel_miim(dev_sel_miim), .dev_wr(dev_wr),
		.dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_ack(dev_ack),
		.dev_rdata(dev_rdata), .autoneg_irq_out(irq), .slow(slow),
		.stall(stall));

	always #5 clock = ~clock;

	// ==================================================================
	// Access and compare tasks
	task automatic summarize;
		if (bad_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		sw_wr <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge clock);
		sw_wr <= 1'b0;
		@(posedge clock);
	endtask : wr

	task automatic rd_raw(input logic [7:0] a, output logic [31:0] d);
		sw_rd <= 1'b1;
		sw_addr <= a;
		@(posedge clock);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
		@(posedge clock);
	endtask : rd_raw

	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m);
		logic [31:0] d;
		rd_raw(a, d);
		chk(d & m, exp);
	endtask : rd

	// Polling paces itself; the cap keeps a hung switch from stalling
	task automatic wait_idle;
		logic [31:0] d;
		d = 32'h1;
		for (int i = 0; i < 400 && d[0] !== 1'b0; i++)
			rd_raw(REG_STATUS, d);
	endtask : wait_idle

	task automatic do_reset;
		arst_n <= 1'b0;
		irq_hi <= 1'b0;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
	endtask : do_reset

	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (irq === 1'b1)
			irq_hi <= 1'b1;
		if (cyc == 20000)
		begin
			bad_count++;
			summarize();
		end
	end

	// ==================================================================
	// Main sequence
	initial
	begin
		clock = 1'b0;
		arst_n = 1'b0;
		sw_addr = 8'h00;
		sw_wdata = 32'h0;
		sw_wr = 1'b0;
		sw_rd = 1'b0;
		slow = 1'b0;
		stall = 1'b0;
		irq_hi = 1'b0;
		bad_count = 0;
		total_checks = 0;
		cyc = 0;
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		rd(REG_CTRL, 32'h0000_0002, 32'hFFFF_FFFF);
		rd(REG_TIMER, 32'h0000_0032, 32'hFFFF_FFFF);
		rd(REG_ADV, 32'h1000_0020, 32'hFFFF_FFFF);
		rd(REG_STATUS, 32'h0000_0010, 32'h0000_001F);
		rd(8'h10, 32'h0, 32'hFFFF_FFFF);
		// Refused: no tri-speed, then an illegal mode
		wr(REG_CTRL, GO | 32'h1);
		rd(REG_STATUS, 32'h0000_0014, 32'h0000_001F);
		wr(REG_CTRL, GO | TRI);
		rd(REG_STATUS, 32'h0000_0014, 32'h0000_001F);
		chk({30'h0, mdl.mode_q}, 32'h2);
		// SGMII to 1000BASE-X, interrupt driven, slow device
		slow <= 1'b1;
		wr(REG_TIMER, 32'd20);
		wr(REG_ADV, 32'h1000_01A0);
		wr(REG_CTRL, GO | TRI | IRQ | 32'h1);
		wait_idle();
		rd(REG_STATUS, 32'h0020_0022, 32'hFFFF_00FF);
		chk({3'h0, mdl.mode_q, 18'h0, mdl.timer_q}, 32'h0800_0014);
		chk({16'h0, mdl.adv_q}, 32'h0000_01A0);
		chk({16'h0, mdl.ctl_q}, 32'h0000_1200);
		chk({31'h0, mdl.transceiver_loopback_out}, 32'h0);
		chk(mdl.mac_q, 32'hA000_0000);
		chk({31'h0, irq_hi}, 32'h1);
		chk({30'h0, mdl.irq_q, mdl.irq_en_q}, 32'h1);
		wr(REG_CTRL, GO | TRI | 32'h2);
		rd(REG_STATUS, 32'h0000_0004, 32'h0000_0015);
		// After reset: SGMII by polling, interrupt left disabled
		do_reset();
		slow <= 1'b0;
		wr(REG_TIMER, 32'd20);
		wr(REG_CTRL, GO | TRI | 32'h2);
		wait_idle();
		rd(REG_STATUS, 32'h0800_0042, 32'hFFFF_00FF);
		chk(mdl.mac_q, 32'h8000_0000);
		chk({31'h0, irq_hi}, 32'h0);
		chk({31'h0, mdl.irq_en_q}, 32'h0);
		// Autoneg never finishes: the switch must time out
		do_reset();
		stall <= 1'b1;
		wr(REG_TIMER, 32'd1);
		wr(REG_CTRL, GO | TRI | IRQ | 32'h1);
		wait_idle();
		rd(REG_STATUS, 32'h0000_0028, 32'h0000_007F);
		summarize();
	end
endmodule : tb_sgmc_ctrl
`default_nettype wire
